//--- verilog/uhi_top.sv
// Holding, divisor and interrupt registers of the UART bridge behind the host port
`timescale 1ns/1ps
`include "uhi_regs.svh"
module uhi_top
	import uhi_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic por,
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rdata_valid,
	output logic reg_wr_nak,
	input wire logic [7:0] line_control,
	input wire logic enh_enable,
	input wire logic fifo_enable,
	input wire logic [1:0] tx_trigger_sel,
	input wire logic [1:0] rx_trigger_sel,
	input wire logic rx_flush,
	input wire logic tx_flush,
	input wire logic rx_push,
	input wire logic [7:0] rx_push_data,
	output logic rx_full,
	input wire logic tx_pop,
	output logic [7:0] tx_pop_data,
	output logic tx_empty,
	input wire logic src_line_err,
	input wire logic src_rx_timeout,
	input wire logic src_modem,
	input wire logic src_pin_change,
	input wire logic src_xoff_special,
	input wire logic src_cts_inactive,
	input wire logic src_rts_inactive,
	input wire logic [3:0] modem_in,
	input wire logic rx_pin,
	output logic [15:0] baud_divisor,
	output logic irq,
	output logic osc_stop,
	output logic uart_clk_en
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	uhi_fifo_if rx_if ();
	uhi_fifo_if tx_if ();

	uhi_byte_t ier_r;
	uhi_byte_t ier_nxt;
	uhi_byte_t iir_r;
	uhi_byte_t iir_nxt;
	uhi_byte_t dll_r;
	uhi_byte_t dlh_r;
	uhi_byte_t rdata_r;
	uhi_byte_t rdata_nxt;
	logic rvalid_r;
	logic nak_r;
	logic irq_r;
	logic [3:0] modem_prev_r;
	uhi_sleep_t sleep_r;
	uhi_sleep_t sleep_nxt;

	logic divisor_mode;
	logic holding_mode;
	logic wr_hold;
	logic rd_hold;
	logic wr_dll;
	logic wr_dlh;
	logic wr_ier;
	uhi_count_t tx_trig;
	uhi_count_t rx_trig;
	uhi_count_t tx_space;
	logic rx_ready;
	logic tx_ready;
	logic p_lstat;
	logic p_rxto;
	logic p_rxrdy;
	logic p_txrdy;
	logic p_modem;
	logic p_pin;
	logic p_xoff;
	logic p_ctsrts;
	logic any_pending;
	logic modem_steady;
	logic sleep_ok;
	logic wake;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic uhi_count_t tx_trig_of(input logic [1:0] sel);
		case (sel)
			2'h0: tx_trig_of = `UHI_TXTRIG_0;
			2'h1: tx_trig_of = `UHI_TXTRIG_1;
			2'h2: tx_trig_of = `UHI_TXTRIG_2;
			default: tx_trig_of = `UHI_TXTRIG_3;
		endcase
	endfunction

	function automatic uhi_count_t rx_trig_of(input logic [1:0] sel);
		case (sel)
			2'h0: rx_trig_of = `UHI_RXTRIG_0;
			2'h1: rx_trig_of = `UHI_RXTRIG_1;
			2'h2: rx_trig_of = `UHI_RXTRIG_2;
			default: rx_trig_of = `UHI_RXTRIG_3;
		endcase
	endfunction

	// Same address decode serves reads and writes
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	// ------------------------------------------------------------
	// FIFOs
	// ------------------------------------------------------------
	uhi_fifo #(
		.AW(6)
	) u_rx_fifo (
		.clk_sys(clk_sys),
		.srst(srst),
		.f(rx_if)
	);

	uhi_fifo #(
		.AW(6)
	) u_tx_fifo (
		.clk_sys(clk_sys),
		.srst(srst),
		.f(tx_if)
	);

	assign rx_if.push = rx_push;
	assign rx_if.push_data = rx_push_data;
	assign rx_if.pop = rd_hold;
	assign rx_if.flush = rx_flush;
	assign rx_if.single = !fifo_enable;
	assign rx_full = rx_if.full;

	assign tx_if.push = wr_hold;
	assign tx_if.push_data = reg_wdata;
	assign tx_if.pop = tx_pop;
	assign tx_if.flush = tx_flush;
	assign tx_if.single = !fifo_enable;
	assign tx_pop_data = tx_if.pop_data;
	assign tx_empty = tx_if.empty;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// The enhanced-access value 0xBF also has bit 7 set, so it must be excluded
	assign divisor_mode = line_control[`UHI_LCR_DLAB]
		&& (line_control != `UHI_LCR_ENH);
	assign holding_mode = !line_control[`UHI_LCR_DLAB];
	assign wr_hold = reg_wr && holding_mode && hit(reg_addr, `UHI_OFF_HOLD);
	assign rd_hold = reg_rd && holding_mode && hit(reg_addr, `UHI_OFF_HOLD);
	assign wr_dll = reg_wr && divisor_mode && hit(reg_addr, `UHI_OFF_HOLD);
	assign wr_dlh = reg_wr && divisor_mode && hit(reg_addr, `UHI_OFF_DLH);
	assign wr_ier = reg_wr && holding_mode && hit(reg_addr, `UHI_OFF_IER);

	// ------------------------------------------------------------
	// Interrupt enable
	// ------------------------------------------------------------
	always_comb
	begin
		ier_nxt = ier_r;
		if (wr_ier)
		begin
			ier_nxt[`UHI_IER_LOCK_LSB-1:0] = reg_wdata[`UHI_IER_LOCK_LSB-1:0];
			// Upper enables stay frozen unless enhanced functions are unlocked
			if (enh_enable)
			begin
				ier_nxt[`UHI_IER_LOCK_MSB:`UHI_IER_LOCK_LSB] =
					reg_wdata[`UHI_IER_LOCK_MSB:`UHI_IER_LOCK_LSB];
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst || por)
		begin
			ier_r <= `UHI_IER_RST;
		end
		else
		begin
			ier_r <= ier_nxt;
		end
	end

	// ------------------------------------------------------------
	// Baud divisor
	// ------------------------------------------------------------
	// Software reset leaves the divisor alone so the line rate survives it
	always_ff @(posedge clk_sys)
	begin
		if (por)
		begin
			dll_r <= `UHI_DLL_RST;
			dlh_r <= `UHI_DLH_RST;
		end
		else
		begin
			if (wr_dll)
			begin
				dll_r <= reg_wdata;
			end
			if (wr_dlh)
			begin
				dlh_r <= reg_wdata;
			end
		end
	end

	assign baud_divisor = {dlh_r, dll_r};

	// ------------------------------------------------------------
	// Interrupt sources
	// ------------------------------------------------------------
	assign tx_trig = tx_trig_of(tx_trigger_sel);
	assign rx_trig = rx_trig_of(rx_trigger_sel);
	assign tx_space = `UHI_FIFO_DEPTH - tx_if.count;
	assign rx_ready = fifo_enable ? (rx_if.count >= rx_trig) : !rx_if.empty;
	assign tx_ready = fifo_enable ? (tx_space > tx_trig) : tx_if.empty;

	assign p_lstat = src_line_err && ier_r[`UHI_IER_LSTAT];
	assign p_rxto = src_rx_timeout && ier_r[`UHI_IER_RXRDY];
	assign p_rxrdy = rx_ready && ier_r[`UHI_IER_RXRDY];
	assign p_txrdy = tx_ready && ier_r[`UHI_IER_TXRDY];
	assign p_modem = src_modem && ier_r[`UHI_IER_MODEM];
	// Enhanced sources only report while enhanced functions are unlocked
	assign p_pin = enh_enable && src_pin_change && ier_r[`UHI_IER_MODEM];
	assign p_xoff = enh_enable && src_xoff_special && ier_r[`UHI_IER_XOFF];
	assign p_ctsrts = enh_enable && ((src_cts_inactive && ier_r[`UHI_IER_CTS])
		|| (src_rts_inactive && ier_r[`UHI_IER_RTS]));

	assign any_pending = p_lstat || p_rxto || p_rxrdy || p_txrdy
		|| p_modem || p_pin || p_xoff || p_ctsrts;

	// ------------------------------------------------------------
	// Interrupt identification
	// ------------------------------------------------------------
	always_comb
	begin
		iir_nxt = `UHI_IIR_RST;
		iir_nxt[7] = fifo_enable;
		iir_nxt[6] = fifo_enable;
		iir_nxt[0] = !any_pending;
		if (p_lstat)
		begin
			iir_nxt[5:1] = `UHI_CODE_LSTAT;
		end
		else if (p_rxto)
		begin
			iir_nxt[5:1] = `UHI_CODE_RXTO;
		end
		else if (p_rxrdy)
		begin
			iir_nxt[5:1] = `UHI_CODE_RXRDY;
		end
		else if (p_txrdy)
		begin
			iir_nxt[5:1] = `UHI_CODE_TXRDY;
		end
		else if (p_modem)
		begin
			iir_nxt[5:1] = `UHI_CODE_MODEM;
		end
		else if (p_pin)
		begin
			iir_nxt[5:1] = `UHI_CODE_PIN;
		end
		else if (p_xoff)
		begin
			iir_nxt[5:1] = `UHI_CODE_XOFF;
		end
		else if (p_ctsrts)
		begin
			iir_nxt[5:1] = `UHI_CODE_CTSRTS;
		end
		else
		begin
			iir_nxt[5:1] = `UHI_CODE_MODEM;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst || por)
		begin
			iir_r <= `UHI_IIR_RST;
		end
		else
		begin
			iir_r <= iir_nxt;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst || por)
		begin
			irq_r <= 1'b0;
		end
		else
		begin
			irq_r <= any_pending;
		end
	end

	assign irq = irq_r;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// An empty receive FIFO still answers; the byte is stale and the host
	// must consult line status before trusting it
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (holding_mode)
		begin
			case (reg_addr)
				`UHI_OFF_HOLD: rdata_nxt = rx_if.pop_data;
				`UHI_OFF_IER: rdata_nxt = ier_r;
				`UHI_OFF_IIR: rdata_nxt = iir_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
		else if (divisor_mode && hit(reg_addr, `UHI_OFF_DLH))
		begin
			rdata_nxt = dlh_r;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst || por)
		begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rvalid_r <= reg_rd;
			if (reg_rd)
			begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rdata_valid = rvalid_r;

	always_ff @(posedge clk_sys)
	begin
		if (srst || por)
		begin
			nak_r <= 1'b0;
		end
		else
		begin
			nak_r <= wr_hold && tx_if.full;
		end
	end

	assign reg_wr_nak = nak_r;

	// ------------------------------------------------------------
	// Sleep control
	// ------------------------------------------------------------
	assign modem_steady = (modem_in == modem_prev_r);
	assign sleep_ok = ier_r[`UHI_IER_SLEEP] && enh_enable && !any_pending
		&& modem_steady && rx_pin && rx_if.empty && tx_if.empty;
	assign wake = !modem_steady || !rx_pin || wr_hold
		|| !ier_r[`UHI_IER_SLEEP] || !enh_enable;

	always_ff @(posedge clk_sys)
	begin
		if (srst || por)
		begin
			modem_prev_r <= 4'h0;
		end
		else
		begin
			modem_prev_r <= modem_in;
		end
	end

	always_comb
	begin
		sleep_nxt = sleep_r;
		case (sleep_r)
			UHI_AWAKE:
			begin
				if (sleep_ok)
				begin
					sleep_nxt = UHI_ASLEEP;
				end
			end
			UHI_ASLEEP:
			begin
				if (wake)
				begin
					sleep_nxt = UHI_AWAKE;
				end
			end
			default: sleep_nxt = UHI_AWAKE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst || por)
		begin
			sleep_r <= UHI_AWAKE;
		end
		else
		begin
			sleep_r <= sleep_nxt;
		end
	end

	// Register port keeps running on clk_sys so the host can always wake the UART
	assign osc_stop = (sleep_r == UHI_ASLEEP);
	assign uart_clk_en = (sleep_r == UHI_AWAKE);
endmodule

//--- verilog/uhi_regs.svh
// Register map, field positions, reset values and interrupt codes of the holding/interrupt block
// Behaviour
// - Reading offset 0 returns the oldest receive byte and removes it.
// - Reading an empty receive FIFO gives a meaningless value; host must ignore it.
// - Writing offset 0 appends the byte to the transmit FIFO tail.
// - A write to a full transmit FIFO is dropped, contents unchanged.
// - Offset 0 is divisor low only when line control bit 7 set and not 0xBF; here divisor low is write-only and reads give 0x00.
// - Divisor low resets to 01; only power-on reset clears the divisor bytes.
// - Divisor high is a read-write 8-bit upper divisor register.
// - Interrupt-enable bits 7..4 change only while enhanced functions are enabled.
// - Sleep entry needs no pending interrupt, steady modem, idle receive, empty FIFOs.
// - Sleep ends on modem toggle, receive input low, or transmit FIFO load.
// - Asleep, the oscillator is stopped and the UART clock gated off.
// - Transmit-ready fires on empty holding, or FIFO space above trigger.
// - Interrupt-enable bits other than bit 4 (sleep) gate their own interrupt sources; bit 3 also gates pin change.
// - Identify bit 0 is one when nothing pends; register resets to 0x01.
// - Bits 5..1 encode the highest pending source, priorities 1 to 4.
// - Enhanced sources encode 0x30, 0x10, 0x20 at priorities 5, 6, 7.
// - FIFO disabled holds one character and trigger acts as one; enabled holds 64.
// - Enhanced enable unlocks upper enables, identify bits 5..4, tx trigger, sleep; tx_trigger_sel here applies without it.
`ifndef UHI_REGS_SVH
`define UHI_REGS_SVH

`define UHI_OFF_HOLD 4'h0
`define UHI_OFF_IER 4'h1
`define UHI_OFF_DLH 4'h1
`define UHI_OFF_IIR 4'h2

`define UHI_LCR_DLAB 7
`define UHI_LCR_ENH 8'hBF

`define UHI_IER_RST 8'h00
`define UHI_IIR_RST 8'h01
`define UHI_DLL_RST 8'h01
`define UHI_DLH_RST 8'h00
`define UHI_IER_LOCK_MSB 7
`define UHI_IER_LOCK_LSB 4
`define UHI_IER_RXRDY 0
`define UHI_IER_TXRDY 1
`define UHI_IER_LSTAT 2
`define UHI_IER_MODEM 3
`define UHI_IER_SLEEP 4
`define UHI_IER_XOFF 5
`define UHI_IER_RTS 6
`define UHI_IER_CTS 7

`define UHI_CODE_LSTAT 5'h03
`define UHI_CODE_RXTO 5'h06
`define UHI_CODE_RXRDY 5'h02
`define UHI_CODE_TXRDY 5'h01
`define UHI_CODE_MODEM 5'h00
`define UHI_CODE_PIN 5'h18
`define UHI_CODE_XOFF 5'h08
`define UHI_CODE_CTSRTS 5'h10

`define UHI_FIFO_DEPTH 7'h40
`define UHI_ONE_CHAR 7'h01
`define UHI_TXTRIG_0 7'h08
`define UHI_TXTRIG_1 7'h10
`define UHI_TXTRIG_2 7'h20
`define UHI_TXTRIG_3 7'h38
`define UHI_RXTRIG_0 7'h08
`define UHI_RXTRIG_1 7'h10
`define UHI_RXTRIG_2 7'h38
`define UHI_RXTRIG_3 7'h3C

`endif

//--- verilog/uhi_pkg.sv
// Types shared by the holding/interrupt register block
package uhi_pkg;
	typedef enum logic [0:0] {
		UHI_AWAKE = 1'b0,
		UHI_ASLEEP = 1'b1
	} uhi_sleep_t;
	typedef logic [7:0] uhi_byte_t;
	typedef logic [6:0] uhi_count_t;
endpackage

//--- verilog/uhi_fifo_if.sv
// Carrier between the register block and one of its byte FIFOs
`timescale 1ns/1ps
interface uhi_fifo_if;
	import uhi_pkg::*;
	logic push;
	uhi_byte_t push_data;
	logic pop;
	uhi_byte_t pop_data;
	logic flush;
	logic single;
	uhi_count_t count;
	logic full;
	logic empty;
	modport store (input push, push_data, pop, flush, single, output pop_data, count, full, empty);
	modport user (output push, push_data, pop, flush, single, input pop_data, count, full, empty);
endinterface

//--- verilog/uhi_fifo.sv
// Byte FIFO whose capacity drops to one entry when FIFO mode is off
`timescale 1ns/1ps
`include "uhi_regs.svh"
module uhi_fifo
	import uhi_pkg::*;
#(
	parameter int AW = 6
)
(
	input wire logic clk_sys,
	input wire logic srst,
	uhi_fifo_if.store f
);
	uhi_byte_t mem [0:(1 << AW) - 1];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	uhi_count_t count_r;
	uhi_count_t cap;
	logic do_push;
	logic do_pop;

	// Non-FIFO mode keeps a single character per direction
	assign cap = f.single ? `UHI_ONE_CHAR : `UHI_FIFO_DEPTH;
	assign f.full = (count_r >= cap);
	assign f.empty = (count_r == 7'h00);
	assign f.count = count_r;
	assign f.pop_data = mem[rd_ptr_r];
	assign do_push = f.push && !f.full;
	assign do_pop = f.pop && !f.empty;

	always_ff @(posedge clk_sys)
	begin
		if (do_push)
		begin
			mem[wr_ptr_r] <= f.push_data;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst || f.flush)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= 7'h00;
		end
		else
		begin
			if (do_push)
			begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (do_pop)
			begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (do_push && !do_pop)
			begin
				count_r <= count_r + 7'h01;
			end
			else if (do_pop && !do_push)
			begin
				count_r <= count_r - 7'h01;
			end
		end
	end
endmodule

//--- tb/uhi_monitor.sv
// Port-level checker for the holding/interrupt register block
`timescale 1ns/1ps
module uhi_monitor
	import uhi_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic por,
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] line_control,
	input wire logic fifo_enable,
	input wire logic rx_flush,
	input wire logic tx_flush,
	input wire logic rx_push,
	input wire logic tx_pop,
	input wire logic rx_full,
	input wire logic tx_empty,
	input wire logic rx_pin,
	input wire logic reg_rdata_valid,
	input wire logic reg_wr_nak,
	input wire logic [15:0] baud_divisor,
	input wire logic osc_stop,
	input wire logic uart_clk_en
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst || por);
	logic hold_wr;
	assign hold_wr = reg_wr && reg_addr == 4'h0 && !line_control[7];
	read_answer_a: assert property (reg_rd |=> reg_rdata_valid)
		else $error("read not answered");
	no_stray_valid_a: assert property (!reg_rd |=> !reg_rdata_valid)
		else $error("valid without read");
	// Single-character mode: a non-empty TX store is a full one
	full_drop_a: assert property (hold_wr && !fifo_enable && !tx_empty && !tx_pop && !tx_flush
		|=> reg_wr_nak)
		else $error("write to full store not refused");
	tx_append_a: assert property (hold_wr && tx_empty && !tx_flush
		|=> !tx_empty && !reg_wr_nak)
		else $error("holding write not stored");
	rx_single_a: assert property (!fifo_enable && rx_push && !rx_full && !reg_rd && !rx_flush
		|=> rx_full)
		else $error("one character does not fill");
	clk_gate_a: assert property (osc_stop == !uart_clk_en)
		else $error("clock gate disagrees with oscillator");
	wake_rx_a: assert property (osc_stop && !rx_pin |=> !osc_stop)
		else $error("no wake on receive low");
	wake_write_a: assert property (osc_stop && hold_wr |=> !osc_stop)
		else $error("no wake on holding write");
	sleep_entry_a: assert property ($rose(osc_stop) |-> $past(tx_empty) && $past(rx_pin))
		else $error("slept while busy");
	div_keep_a: assert property (disable iff (por) srst |=> $stable(baud_divisor))
		else $error("software reset touched divisor");
	div_por_a: assert property (disable iff (1'b0) por |=> baud_divisor == 16'h0001)
		else $error("divisor power-on value wrong");
endmodule

bind uhi_top uhi_monitor u_uhi_monitor (.clk_sys(clk_sys), .srst(srst), .por(por),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .line_control(line_control),
	.fifo_enable(fifo_enable), .rx_flush(rx_flush), .tx_flush(tx_flush), .rx_push(rx_push),
	.tx_pop(tx_pop), .rx_full(rx_full), .tx_empty(tx_empty), .rx_pin(rx_pin),
	.reg_rdata_valid(reg_rdata_valid), .reg_wr_nak(reg_wr_nak),
	.baud_divisor(baud_divisor), .osc_stop(osc_stop), .uart_clk_en(uart_clk_en));

//--- tb/uhi_host.sv
// Host model issuing one register cycle at a time
`timescale 1ns/1ps
module uhi_host
(
	input wire logic clk_sys,
	output logic [3:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rdata_valid,
	input wire logic reg_wr_nak
);
	initial
	begin
		reg_addr = 4'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// Released data flips so a stale byte is never mistaken for a held one
	task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic nak);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		#1;
		nak = reg_wr_nak;
	endtask
	task automatic rd(input logic [3:0] a, output logic [8:0] r);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		r = {reg_rdata_valid, reg_rdata};
	endtask
endmodule

//--- tb/uart_holding_irq_regs_bench.sv
// Self-checking bench for the holding/interrupt register block
`timescale 1ns/1ps
module uart_holding_irq_regs_bench;
	import uhi_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic por = 1'b1;
	logic [3:0] reg_addr;
	logic reg_wr, reg_rd, reg_rdata_valid, reg_wr_nak, n, rx_full, tx_empty, irq;
	logic [7:0] reg_wdata, reg_rdata, tx_pop_data, d, dl, dh;
	logic [7:0] line_control = 8'h00;
	logic enh_enable = 1'b0;
	logic fifo_enable = 1'b0;
	logic rx_push = 1'b0;
	logic tx_pop = 1'b0;
	logic rx_pin = 1'b1;
	logic [3:0] modem_in = 4'h0;
	logic [1:0] tx_trigger_sel = 2'h0;
	logic [7:0] rx_push_data = 8'h00;
	logic [6:0] src = 7'h00;
	logic [15:0] baud_divisor;
	logic osc_stop, uart_clk_en;
	logic [8:0] r;
	logic [7:0] q[$];
	int err_total = 0;
	int n_checks = 0;
	always #10 clk_sys = ~clk_sys;
	uhi_host u_uhi_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rdata_valid(reg_rdata_valid), .reg_wr_nak(reg_wr_nak));
	uhi_top u_uhi_top (.clk_sys(clk_sys), .srst(srst), .por(por), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rdata_valid(reg_rdata_valid), .reg_wr_nak(reg_wr_nak),
		.line_control(line_control), .enh_enable(enh_enable), .fifo_enable(fifo_enable),
		.tx_trigger_sel(tx_trigger_sel), .rx_trigger_sel(2'h0), .rx_flush(1'b0),
		.tx_flush(1'b0),
		.rx_push(rx_push), .rx_push_data(rx_push_data), .rx_full(rx_full), .tx_pop(tx_pop),
		.tx_pop_data(tx_pop_data), .tx_empty(tx_empty), .src_line_err(src[0]),
		.src_rx_timeout(src[1]), .src_modem(src[2]), .src_pin_change(src[3]),
		.src_xoff_special(src[4]), .src_cts_inactive(src[5]), .src_rts_inactive(src[6]),
		.modem_in(modem_in), .rx_pin(rx_pin), .baud_divisor(baud_divisor), .irq(irq),
		.osc_stop(osc_stop), .uart_clk_en(uart_clk_en));
	task automatic stop_test();
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e)
		begin
			$display("mismatch %s expected %h seen %h", w, e, s);
			err_total++;
		end
	endtask
	task automatic wait_sleep();
		int i;
		i = 0;
		while (osc_stop !== 1'b1 && i < 50)
		begin
			@(posedge clk_sys);
			#1;
			i++;
		end
		if (i == 50)
		begin
			err_total++;
			stop_test();
		end
	endtask
	// Model of the identify byte with every source enabled, FIFO mode on
	function automatic logic [7:0] iir_model(input logic [6:0] s, input logic txr);
		logic [7:0] c;
		c = 8'h00;
		if (s[0]) c = 8'h06;
		else if (s[1]) c = 8'h0C;
		else if (txr) c = 8'h02;
		else if (s[2]) c = 8'h00;
		else if (s[3]) c = 8'h30;
		else if (s[4]) c = 8'h10;
		else if (s[5] || s[6]) c = 8'h20;
		return 8'hC0 | c | {7'h00, !(|s || txr)};
	endfunction
	initial
	begin
		void'($urandom(32'h9184));
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		por <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("divisor por", baud_divisor, 16'h0001);
		u_uhi_host.rd(4'h2, r);
		chk("iir reset", r, 9'h101);
		line_control <= 8'h80;
		dl = $urandom;
		dh = $urandom;
		u_uhi_host.wr(4'h0, dl, n);
		u_uhi_host.wr(4'h1, dh, n);
		chk("divisor", baud_divisor, {dh, dl});
		u_uhi_host.rd(4'h1, r);
		chk("divisor high", r, {1'b1, dh});
		line_control <= 8'hBF;
		u_uhi_host.wr(4'h0, ~dl, n);
		chk("divisor enh page", baud_divisor, {dh, dl});
		srst <= 1'b1;
		@(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("divisor srst", baud_divisor, {dh, dl});
		line_control <= 8'h00;
		u_uhi_host.wr(4'h1, 8'hFF, n);
		u_uhi_host.rd(4'h1, r);
		chk("ier locked", r, 9'h10F);
		enh_enable <= 1'b1;
		u_uhi_host.wr(4'h1, 8'hF0, n);
		u_uhi_host.rd(4'h1, r);
		chk("ier unlocked", r, 9'h1F0);
		// A steady modem lets the block fall asleep again one edge after waking
		for (int k = 0; k < 3; k++)
		begin
			wait_sleep();
			chk("asleep", {osc_stop, uart_clk_en}, 16'h2);
			if (k == 0)
				rx_pin <= 1'b0;
			else if (k == 1)
				modem_in <= ~modem_in;
			else
				u_uhi_host.wr(4'h0, 8'h33, n);
			@(posedge clk_sys);
			#1;
			rx_pin <= 1'b1;
			chk("awake", {osc_stop, uart_clk_en}, 16'h1);
		end
		// Single-character mode: a second byte finds the store full
		u_uhi_host.wr(4'h0, 8'hCC, n);
		chk("nak single", n, 1);
		chk("tx head", tx_pop_data, 8'h33);
		tx_pop <= 1'b1;
		@(posedge clk_sys);
		tx_pop <= 1'b0;
		u_uhi_host.wr(4'h1, 8'hED, n);
		fifo_enable <= 1'b1;
		for (int i = 0; i < 65; i++)
		begin
			d = $urandom;
			if (i < 64)
				q.push_back(d);
			u_uhi_host.wr(4'h0, d, n);
		end
		chk("nak when full", n, 1);
		tx_pop <= 1'b1;
		for (int i = 0; i < 64; i++)
		begin
			chk("tx data", tx_pop_data, q.pop_front());
			@(posedge clk_sys);
			#1;
		end
		tx_pop <= 1'b0;
		chk("tx empty", tx_empty, 1);
		rx_push <= 1'b1;
		for (int i = 0; i < 65; i++)
		begin
			d = $urandom;
			if (i < 64)
				q.push_back(d);
			rx_push_data <= d;
			@(posedge clk_sys);
			#1;
		end
		rx_push <= 1'b0;
		chk("rx full", rx_full, 1);
		for (int i = 0; i < 64; i++)
		begin
			u_uhi_host.rd(4'h0, r);
			chk("rx data", r, {1'b1, q.pop_front()});
		end
		// Empty read: value discarded, nothing popped
		u_uhi_host.rd(4'h0, r);
		d = $urandom;
		rx_push <= 1'b1;
		rx_push_data <= d;
		@(posedge clk_sys);
		rx_push <= 1'b0;
		u_uhi_host.rd(4'h0, r);
		chk("rx after empty", r, {1'b1, d});
		for (int j = 6; j >= 0; j--)
		begin
			src[j] <= 1'b1;
			repeat (2) @(posedge clk_sys);
			u_uhi_host.rd(4'h2, r);
			chk("iir priority", r, {1'b1, iir_model(src, 1'b0)});
			chk("irq", irq, 1);
		end
		u_uhi_host.wr(4'h1, 8'h00, n);
		repeat (2) @(posedge clk_sys);
		u_uhi_host.rd(4'h2, r);
		chk("iir masked", r, 9'h1C1);
		chk("irq masked", irq, 0);
		src <= 7'h00;
		u_uhi_host.wr(4'h1, 8'h02, n);
		repeat (2) @(posedge clk_sys);
		u_uhi_host.rd(4'h2, r);
		chk("iir tx ready", r, {1'b1, iir_model(7'h00, 1'b1)});
		chk("irq tx ready", irq, 1);
		// Trigger of 56 spaces: eight bytes leave exactly 56, one pop makes 57
		tx_trigger_sel <= 2'h3;
		for (int i = 0; i < 8; i++)
			u_uhi_host.wr(4'h0, 8'h3C, n);
		repeat (2) @(posedge clk_sys);
		u_uhi_host.rd(4'h2, r);
		chk("iir at trigger", r, 9'h1C1);
		chk("irq at trigger", irq, 0);
		tx_pop <= 1'b1;
		@(posedge clk_sys);
		tx_pop <= 1'b0;
		repeat (2) @(posedge clk_sys);
		u_uhi_host.rd(4'h2, r);
		chk("iir above trigger", r, 9'h1C2);
		fifo_enable <= 1'b0;
		rx_push <= 1'b1;
		rx_push_data <= 8'h5A;
		@(posedge clk_sys);
		rx_push_data <= 8'hA5;
		@(posedge clk_sys);
		rx_push <= 1'b0;
		#1;
		chk("rx single full", rx_full, 1);
		u_uhi_host.rd(4'h0, r);
		chk("rx single data", r, 9'h15A);
		stop_test();
	end
endmodule
